//--- hw/dcp_ctrl.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module dcp_ctrl (
    // clock and resets
    input wire logic clk,
    input wire logic reset_n,
    input wire logic soft_reset,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // nonvolatile configuration image
    input wire logic [1:0] nvm_swpin_value,
    input wire logic [1:0] nvm_swpin_direction,
    input wire logic nvm_wake_advertise_en,
    input wire logic nvm_phy_power_speed_mgmt_en,
    // general pins
    input wire logic [1:0] swpin_in,
    output logic [1:0] swpin_out,
    output logic [1:0] swpin_oe,
    // power and phy
    input wire logic aux_power_present,
    input wire logic phy_duplex_full,
    input wire dcp_pkg::dcp_pwr_type pwr_state,
    input wire logic wake_or_mng_en,
    output logic duplex_full,
    output logic d3cold_wake_advertise,
    output logic phy_auto_speed_en,
    output logic phy_advertise_gig,
    output logic phy_renegotiate
);

    dcp_pkg::dcp_state_type s_q;
    dcp_pkg::dcp_state_type s_d;
    logic hit;
    logic wr;
    logic want_low;

    function automatic logic [31:0] ctrl_read(dcp_pkg::dcp_state_type s);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[dcp_pkg::DCP_DUPLEX_SEL_BIT] = s.duplex_sel;
        r[dcp_pkg::DCP_FRC_BIT] = s.frc;
        r[dcp_pkg::DCP_VAL0_BIT] = s.dir[0] ? s.value[0] : s.pin_sync[0];
        r[dcp_pkg::DCP_VAL1_BIT] = s.dir[1] ? s.value[1] : s.pin_sync[1];
        r[dcp_pkg::DCP_ADV_BIT] = s.adv_en;
        r[dcp_pkg::DCP_PWR_BIT] = s.pwr_en;
        r[dcp_pkg::DCP_DIR0_BIT] = s.dir[0];
        r[dcp_pkg::DCP_DIR1_BIT] = s.dir[1];
        return r;
    endfunction : ctrl_read

    assign hit = (paddr == dcp_pkg::DCP_CTRL_OFFSET);
    assign wr = psel & penable & pwrite & hit;
    assign want_low = (pwr_state != dcp_pkg::DCP_PWR_D0) & wake_or_mng_en;

    always_comb begin
        s_d = s_q;
        // first stage feeds only the second
        s_d.pin_meta = swpin_in;
        s_d.pin_sync = s_q.pin_meta;
        s_d.aux_meta = aux_power_present;
        s_d.aux_sync = s_q.aux_meta;
        s_d.reneg = 1'b0;
        if (!s_q.loaded) begin
            // image taken on the first edge after power-on release
            s_d.loaded = 1'b1;
            s_d.value = nvm_swpin_value;
            s_d.dir = nvm_swpin_direction;
            s_d.adv_en = nvm_wake_advertise_en;
            s_d.pwr_en = nvm_phy_power_speed_mgmt_en;
        end else if (soft_reset) begin
            // direction bits deliberately not reloaded
            s_d.duplex_sel = dcp_pkg::DCP_DUPLEX_SEL_RST;
            s_d.frc = dcp_pkg::DCP_FRC_RST;
            s_d.value = nvm_swpin_value;
            s_d.adv_en = nvm_wake_advertise_en;
            s_d.pwr_en = nvm_phy_power_speed_mgmt_en;
        end else if (wr) begin
            // reserved bits are simply not stored
            s_d.duplex_sel = pwdata[dcp_pkg::DCP_DUPLEX_SEL_BIT];
            s_d.frc = pwdata[dcp_pkg::DCP_FRC_BIT];
            s_d.value[0] = pwdata[dcp_pkg::DCP_VAL0_BIT];
            s_d.value[1] = pwdata[dcp_pkg::DCP_VAL1_BIT];
            s_d.adv_en = pwdata[dcp_pkg::DCP_ADV_BIT];
            s_d.pwr_en = pwdata[dcp_pkg::DCP_PWR_BIT];
            s_d.dir[0] = pwdata[dcp_pkg::DCP_DIR0_BIT];
            s_d.dir[1] = pwdata[dcp_pkg::DCP_DIR1_BIT];
        end
        // speed held when management is off, whatever the power state
        if (s_q.pwr_en && (want_low != s_q.low_speed)) begin
            s_d.low_speed = want_low;
            s_d.reneg = 1'b1;
        end
        s_d.duplex = s_q.frc ? s_q.duplex_sel : phy_duplex_full;
        s_d.wake = s_q.adv_en & s_q.aux_sync;
        if (psel && !penable) begin
            s_d.rdata = hit ? ctrl_read(s_q) : dcp_pkg::DCP_RDATA_RST;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q.pin_meta <= dcp_pkg::DCP_SYNC_RST;
            s_q.pin_sync <= dcp_pkg::DCP_SYNC_RST;
            s_q.aux_meta <= 1'b0;
            s_q.aux_sync <= 1'b0;
            s_q.loaded <= 1'b0;
            s_q.duplex_sel <= dcp_pkg::DCP_DUPLEX_SEL_RST;
            s_q.frc <= dcp_pkg::DCP_FRC_RST;
            s_q.value <= dcp_pkg::DCP_VAL_RST;
            s_q.dir <= dcp_pkg::DCP_DIR_RST;
            s_q.adv_en <= dcp_pkg::DCP_ADV_RST;
            s_q.pwr_en <= dcp_pkg::DCP_PWR_RST;
            s_q.low_speed <= 1'b0;
            s_q.reneg <= 1'b0;
            s_q.duplex <= 1'b0;
            s_q.wake <= 1'b0;
            s_q.rdata <= dcp_pkg::DCP_RDATA_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // zero-wait slave: every access phase completes at once
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = s_q.rdata;
    assign swpin_out = s_q.value;
    assign swpin_oe = s_q.dir;
    assign duplex_full = s_q.duplex;
    assign d3cold_wake_advertise = s_q.wake;
    assign phy_auto_speed_en = s_q.pwr_en;
    assign phy_advertise_gig = ~s_q.low_speed;
    assign phy_renegotiate = s_q.reneg;

    a_duplex_forced: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_q.frc |=> (duplex_full == $past(s_q.duplex_sel)))
        else $error("forced duplex not taken from select bit");

    a_duplex_phy: assert property (
        @(posedge clk) disable iff (!reset_n)
        !s_q.frc |=> (duplex_full == $past(phy_duplex_full)))
        else $error("duplex does not follow phy");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!reset_n)
        (prdata[17:13] == 5'h00) && (prdata[25:24] == 2'h0))
        else $error("reserved bits read nonzero");

    a_pin0_read: assert property (
        @(posedge clk) disable iff (!reset_n)
        (psel && !penable && hit && !s_q.dir[0]) |=>
        (prdata[dcp_pkg::DCP_VAL0_BIT] == $past(s_q.pin_sync[0])))
        else $error("pin 0 input level not returned");

    a_pin0_drive: assert property (
        @(posedge clk) disable iff (!reset_n)
        (wr && !soft_reset && s_q.loaded) |=>
        (swpin_out[0] == $past(pwdata[dcp_pkg::DCP_VAL0_BIT])))
        else $error("pin 0 drive level not written");

    a_pin1_read: assert property (
        @(posedge clk) disable iff (!reset_n)
        (psel && !penable && hit && !s_q.dir[1]) |=>
        (prdata[dcp_pkg::DCP_VAL1_BIT] == $past(s_q.pin_sync[1])))
        else $error("pin 1 input level not returned");

    a_pin1_drive: assert property (
        @(posedge clk) disable iff (!reset_n)
        (wr && !soft_reset && s_q.loaded) |=>
        (swpin_out[1] == $past(pwdata[dcp_pkg::DCP_VAL1_BIT])))
        else $error("pin 1 drive level not written");

    a_dir_write: assert property (
        @(posedge clk) disable iff (!reset_n)
        (wr && !soft_reset && s_q.loaded) |=>
        (swpin_oe == {$past(pwdata[dcp_pkg::DCP_DIR1_BIT]),
                      $past(pwdata[dcp_pkg::DCP_DIR0_BIT])}))
        else $error("direction write not applied");

    a_dir_keep: assert property (
        @(posedge clk) disable iff (!reset_n)
        (soft_reset && s_q.loaded) |=> $stable(swpin_oe))
        else $error("soft reset changed pin direction");

    a_wake_adv: assert property (
        @(posedge clk) disable iff (!reset_n)
        ##1 (d3cold_wake_advertise == $past(s_q.adv_en & s_q.aux_sync)))
        else $error("wake advertisement wrong");

    a_speed_low: assert property (
        @(posedge clk) disable iff (!reset_n)
        (s_q.pwr_en && want_low && !s_q.low_speed) |=>
        (phy_renegotiate && !phy_advertise_gig))
        else $error("no low speed renegotiation");

    a_speed_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        !s_q.pwr_en |=> (!phy_renegotiate && $stable(phy_advertise_gig)))
        else $error("speed changed while management off");

    a_nvm_load: assert property (
        @(posedge clk) disable iff (!reset_n)
        !s_q.loaded |=> (swpin_oe == $past(nvm_swpin_direction)) &&
        (phy_auto_speed_en == $past(nvm_phy_power_speed_mgmt_en)))
        else $error("nvm image not loaded");

endmodule : dcp_ctrl

`default_nettype wire

//--- hw/dcp_pkg.sv
`default_nettype none
package dcp_pkg;

    // register map
    localparam logic [31:0] DCP_CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] DCP_RDATA_RST = 32'h0000_0000;

    // field positions within device_control
    localparam int unsigned DCP_DUPLEX_SEL_BIT = 0;
    localparam int unsigned DCP_FRC_BIT = 12;
    localparam int unsigned DCP_VAL0_BIT = 18;
    localparam int unsigned DCP_VAL1_BIT = 19;
    localparam int unsigned DCP_ADV_BIT = 20;
    localparam int unsigned DCP_PWR_BIT = 21;
    localparam int unsigned DCP_DIR0_BIT = 22;
    localparam int unsigned DCP_DIR1_BIT = 23;

    // values after reset, before the nonvolatile image is taken
    localparam logic DCP_DUPLEX_SEL_RST = 1'h0;
    localparam logic DCP_FRC_RST = 1'h0;
    localparam logic [1:0] DCP_VAL_RST = 2'h0;
    localparam logic [1:0] DCP_DIR_RST = 2'h0;
    localparam logic DCP_ADV_RST = 1'h0;
    localparam logic DCP_PWR_RST = 1'h0;
    localparam logic [1:0] DCP_SYNC_RST = 2'h0;

    typedef enum logic [1:0] {
        DCP_PWR_D0,
        DCP_PWR_D0U,
        DCP_PWR_D3
    } dcp_pwr_type;

    typedef struct packed {
        logic [1:0] pin_meta;
        logic [1:0] pin_sync;
        logic aux_meta;
        logic aux_sync;
        logic loaded;
        logic duplex_sel;
        logic frc;
        logic [1:0] value;
        logic [1:0] dir;
        logic adv_en;
        logic pwr_en;
        logic low_speed;
        logic reneg;
        logic duplex;
        logic wake;
        logic [31:0] rdata;
    } dcp_state_type;

endpackage : dcp_pkg
`default_nettype wire

//--- verification/dcp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcp_pin_model (
    // block side
    input wire logic [1:0] swpin_out,
    input wire logic [1:0] swpin_oe,
    output logic [1:0] swpin_in,
    // outside driver, seen only where the block lets go
    input wire logic [1:0] ext_level
);
    assign swpin_in = (swpin_oe & swpin_out) | (~swpin_oe & ext_level);
endmodule : dcp_pin_model
`default_nettype wire

//--- verification/device_control_pin_power_bits_test.sv
`timescale 1ns/1ps
`default_nettype none
module device_control_pin_power_bits_test;
    logic clk, reset_n, soft_reset, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [1:0] nvm_swpin_value, nvm_swpin_direction, swpin_in, swpin_out;
    logic [1:0] swpin_oe, ext_level;
    logic nvm_wake_advertise_en, nvm_phy_power_speed_mgmt_en, err;
    logic aux_power_present, phy_duplex_full, wake_or_mng_en, duplex_full;
    logic d3cold_wake_advertise, phy_auto_speed_en, phy_advertise_gig;
    logic phy_renegotiate;
    dcp_pkg::dcp_pwr_type pwr_state;
    int fails = 0;
    int num_checks = 0;
    int pulses = 0;
    localparam logic [31:0] M_V0 = 32'h0004_0000;
    localparam logic [31:0] M_V1 = 32'h0008_0000;
    localparam logic [31:0] M_ADV = 32'h0010_0000;
    localparam logic [31:0] M_PWR = 32'h0020_0000;
    localparam logic [31:0] M_DIR = 32'h00C0_0000;
    localparam logic [31:0] ALL = 32'h00FC_1001;

    dcp_ctrl u_dut (.clk, .reset_n, .soft_reset, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .nvm_swpin_value,
        .nvm_swpin_direction, .nvm_wake_advertise_en,
        .nvm_phy_power_speed_mgmt_en, .swpin_in, .swpin_out, .swpin_oe,
        .aux_power_present, .phy_duplex_full, .pwr_state, .wake_or_mng_en,
        .duplex_full, .d3cold_wake_advertise, .phy_auto_speed_en,
        .phy_advertise_gig, .phy_renegotiate);
    dcp_pin_model u_pins (.swpin_out, .swpin_oe, .swpin_in, .ext_level);

    // a pulse lasts one cycle, so count it rather than poll for it
    always @(posedge clk) if (phy_renegotiate === 1'b1) pulses <= pulses + 1;

    task wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    task check(input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check

    task apb(input logic w, input logic [31:0] a, d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the slave
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task stop_test;
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    task t_power_on;
        apb(1'b0, 32'h0, 32'h0);
        check(rd, M_V0 | M_ADV | M_PWR | 32'h0080_0000);
        check(swpin_oe, 2'h2);
        check(swpin_out, 2'h1);
    endtask : t_power_on

    task t_reg_duplex;
        apb(1'b1, 32'h0, ALL);
        apb(1'b0, 32'h0, 32'h0);
        check(rd, ALL);
        check({swpin_oe, swpin_out}, 4'hF);
        check(duplex_full, 1'b1);
        apb(1'b1, 32'h4, 32'h0);
        check(err, 1'b1);
        apb(1'b0, 32'h4, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 32'h0, ALL & ~32'h0000_1000);
        wait_clk(3);
        check(duplex_full, 1'b0);
        phy_duplex_full <= 1'b1;
        wait_clk(3);
        check(duplex_full, 1'b1);
    endtask : t_reg_duplex

    task t_pins_in;
        apb(1'b1, 32'h0, M_V0 | M_V1);
        ext_level <= 2'h2;
        wait_clk(4);
        apb(1'b0, 32'h0, 32'h0);
        check(rd & (M_V0 | M_V1), M_V1);
        check(swpin_oe, 2'h0);
        ext_level <= 2'h1;
        wait_clk(4);
        apb(1'b0, 32'h0, 32'h0);
        check(rd & (M_V0 | M_V1), M_V0);
    endtask : t_pins_in

    task t_soft;
        apb(1'b1, 32'h0, M_DIR);
        soft_reset <= 1'b1;
        wait_clk(2);
        soft_reset <= 1'b0;
        apb(1'b0, 32'h0, 32'h0);
        check(rd, M_V0 | M_ADV | M_PWR | M_DIR);
        check(swpin_oe, 2'h3);
    endtask : t_soft

    task t_wake;
        aux_power_present <= 1'b0;
        wait_clk(6);
        check(d3cold_wake_advertise, 1'b0);
        aux_power_present <= 1'b1;
        wait_clk(6);
        check(d3cold_wake_advertise, 1'b1);
        apb(1'b1, 32'h0, M_PWR | M_DIR);
        wait_clk(3);
        check(d3cold_wake_advertise, 1'b0);
    endtask : t_wake

    task t_speed;
        int p;
        p = pulses;
        for (int s = 1; s < 3; s++) begin
            pwr_state <= dcp_pkg::dcp_pwr_type'(s);
            wait_clk(4);
            check(phy_advertise_gig, 1'b0);
            pwr_state <= dcp_pkg::DCP_PWR_D0;
            wait_clk(4);
            check(phy_advertise_gig, 1'b1);
        end
        wake_or_mng_en <= 1'b0;
        pwr_state <= dcp_pkg::DCP_PWR_D3;
        wait_clk(4);
        check(phy_advertise_gig, 1'b1);
        // management off first, then a wake_or_mng_en rise in D3 that must not renegotiate
        apb(1'b1, 32'h0, M_DIR);
        wake_or_mng_en <= 1'b1;
        wait_clk(4);
        check(phy_auto_speed_en, 1'b0);
        check(phy_advertise_gig, 1'b1);
        check(pulses - p, 4);
    endtask : t_speed

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        reset_n = 1'b0;
        {soft_reset, psel, penable, pwrite, phy_duplex_full} = 5'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        {nvm_swpin_value, nvm_swpin_direction, ext_level} = 6'h19;
        {nvm_wake_advertise_en, nvm_phy_power_speed_mgmt_en} = 2'h3;
        {aux_power_present, wake_or_mng_en} = 2'h3;
        pwr_state = dcp_pkg::DCP_PWR_D0;
        wait_clk(10);
        reset_n <= 1'b1;
        wait_clk(2);
        t_power_on;
        t_reg_duplex;
        t_pins_in;
        t_soft;
        t_wake;
        t_speed;
        stop_test;
    end

    initial begin
        #200000;
        fails++;
        stop_test;
    end
endmodule : device_control_pin_power_bits_test
`default_nettype wire
